//--- eil_pin_model.sv
// Far-side circuit: a switch that pulls the interrupt pin low.
// Assumes the pin has a pull-up, so a released pin reads high.
`timescale 1ns/1ps
`default_nettype none
module eil_pin_model (
	input  wire logic pull_low_i, // Close the switch
	output logic      pin_n_o     // Pin as seen by the block
);
	// A released pin goes to the pull-up level, never to the last value driven.
	assign pin_n_o = pull_low_i ? 1'h0 : 1'h1;
endmodule
`default_nettype wire

//--- eil_pkg.sv
// Constants, register layout and reset values for the external interrupt latch.
// Assumes a single 25 MHz bus clock and an 8-bit register port behind the CPU bus.
package eil_pkg;
	localparam int unsigned EIL_AW = 2;
	localparam logic [EIL_AW-1:0] EIL_OFS_CTRL    = 2'h0;
	localparam logic [EIL_AW-1:0] EIL_OFS_IRQ_ST  = 2'h1;
	localparam logic [EIL_AW-1:0] EIL_OFS_IRQ_CLR = 2'h2;
	localparam logic [EIL_AW-1:0] EIL_OFS_IRQ_EN  = 2'h3;
	localparam int unsigned EIL_BIT_MODE = 0;
	localparam int unsigned EIL_BIT_MASK = 1;
	localparam int unsigned EIL_BIT_ACK  = 2;
	localparam int unsigned EIL_BIT_PEND = 3;
	localparam int unsigned EIL_EV_EDGE  = 0;
	localparam int unsigned EIL_EV_ACK   = 1;
	localparam int unsigned EIL_NEV      = 2;
	localparam logic [15:0] EIL_VECTOR_ADDR = 16'hfffa;
	localparam logic EIL_MODE_RST = 1'h0;
	localparam logic EIL_MASK_RST = 1'h0;
	localparam logic [2:0] EIL_SETTLE_CYC = 3'h7;
endpackage

//--- eil_top.sv
// External interrupt latch: pin edge/level detection, latch, mask and register port.
// Assumes the CPU signals vector fetch and break state as same-clock pulses and levels.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module eil_top (
	input  wire logic                       clk_i,         // 25 MHz bus clock
	input  wire logic                       rst_n_i,       // Synchronous reset, low active
	input  wire logic                       irq_pin_n_i,   // External pin, low active
	input  wire logic                       vec_fetch_i,   // CPU fetches this vector
	input  wire logic                       break_i,       // System break state
	input  wire logic                       break_clear_enable_i, // Clears allowed in break
	input  wire logic [eil_pkg::EIL_AW-1:0] addr_i,        // Register address
	input  wire logic [7:0]                 wdata_i,       // Write data
	input  wire logic                       we_i,          // Write strobe
	input  wire logic                       re_i,          // Read strobe
	output logic      [7:0]                 rdata_o,       // Read data, cycle after strobe
	output logic                            cpu_irq_o,     // Request to priority logic
	output logic      [15:0]                vector_addr_o, // Vector address for the CPU
	output logic                            pin_level_o,   // Pin level for branch tests
	output logic                            irq_o          // Summary block interrupt
);
	import eil_pkg::*;

	logic [2:0]         sync_q;
	logic               prev_q;
	logic               latch_q;
	logic               ack_pend_q;
	logic               mode_q;
	logic               mask_q;
	logic [EIL_NEV-1:0] ist_q;
	logic [EIL_NEV-1:0] ien_q;
	logic [7:0]         rdata_q;
	logic               pin_q;
	logic               fall_edge;
	logic               pin_low;
	logic               sw_ack;
	logic               ack_any;
	logic               clr_now;
	logic               wr_ctrl;
	logic [2:0]         settle_q;
	logic               settled;

	// Three stages; a level is accepted once stages two and three agree.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sync_q <= 3'h7;
		end else begin
			sync_q <= {sync_q[1:0], irq_pin_n_i};
		end
	end

	// Filtered pin holds its value while the late stages disagree.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pin_q  <= 1'h1;
			prev_q <= 1'h1;
		end else begin
			if (sync_q[1] == sync_q[2]) begin
				pin_q <= sync_q[2];
			end
			prev_q <= pin_q;
		end
	end

	// The synchroniser comes out of reset showing a high pin, so a pin held low
	// through reset would look like a falling edge. Edges count only once the
	// stages have filled with real samples, so reset clears even with the pin low.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			settle_q <= 3'h0;
		end else if (settle_q != EIL_SETTLE_CYC) begin
			settle_q <= settle_q + 3'h1;
		end
	end

	assign settled   = (settle_q == EIL_SETTLE_CYC);
	assign fall_edge = settled & prev_q & ~pin_q;
	assign pin_low   = ~pin_q;
	assign wr_ctrl   = we_i && (addr_i == EIL_OFS_CTRL);
	// Break gating keeps software acknowledges from clearing the latch while the debugger halts the core; vector fetch is not gated.
	assign sw_ack  = wr_ctrl && wdata_i[EIL_BIT_ACK] && (!break_i || break_clear_enable_i);
	assign ack_any = sw_ack || vec_fetch_i;
	// Level mode needs both an acknowledge and the pin high; either may come first.
	assign clr_now = mode_q ? ((ack_any || ack_pend_q) && !pin_low) : ack_any;

	// Set wins over clear so an edge coinciding with an acknowledge is kept.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			latch_q <= 1'h0;
		end else if (fall_edge || (mode_q && pin_low && latch_q)) begin
			latch_q <= 1'h1;
		end else if (clr_now) begin
			latch_q <= 1'h0;
		end
	end

	// Remembers an acknowledge seen in level mode while the pin is still low.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ack_pend_q <= 1'h0;
		end else if (!latch_q || clr_now || !mode_q || fall_edge) begin
			ack_pend_q <= 1'h0;
		end else if (ack_any) begin
			ack_pend_q <= 1'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			mode_q <= EIL_MODE_RST;
			mask_q <= EIL_MASK_RST;
		end else if (wr_ctrl) begin
			mode_q <= wdata_i[EIL_BIT_MODE];
			mask_q <= wdata_i[EIL_BIT_MASK];
		end
	end

	// Block interrupt: edge events and accepted software acknowledges, clear wins never over set.
	logic [EIL_NEV-1:0] ev;
	assign ev = {sw_ack, fall_edge};
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ist_q <= '0;
			ien_q <= '0;
		end else begin
			ist_q <= ev | (ist_q & ~((we_i && addr_i == EIL_OFS_IRQ_CLR) ?
				wdata_i[EIL_NEV-1:0] : {EIL_NEV{1'b0}}));
			if (we_i && addr_i == EIL_OFS_IRQ_EN) begin
				ien_q <= wdata_i[EIL_NEV-1:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_q <= 8'h00;
		end else if (re_i) begin
			unique case (addr_i)
				EIL_OFS_CTRL: begin
					rdata_q <= {4'h0, latch_q, 1'b0, mask_q, mode_q};
				end
				EIL_OFS_IRQ_ST: begin
					rdata_q <= {6'h00, ist_q};
				end
				EIL_OFS_IRQ_EN: begin
					rdata_q <= {6'h00, ien_q};
				end
				default: begin
					rdata_q <= 8'h00;
				end
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign rdata_o       = rdata_q;
	assign cpu_irq_o     = latch_q && !mask_q;
	assign vector_addr_o = EIL_VECTOR_ADDR;
	assign pin_level_o   = pin_q;
	assign irq_o         = |(ist_q & ien_q);

	edge_sets_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		fall_edge |=> latch_q) else $error("edge did not set latch");
	vec_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!mode_q && vec_fetch_i && !fall_edge) |=> !latch_q)
		else $error("vector fetch did not clear");
	sw_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!mode_q && sw_ack && !fall_edge) |=> !latch_q)
		else $error("software ack did not clear");
	level_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(mode_q && latch_q && pin_low) |=> latch_q)
		else $error("level request dropped");
	mask_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cpu_irq_o == (latch_q && !mask_q)) else $error("mask gating wrong");
	ack_reads0_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		re_i |=> !rdata_o[EIL_BIT_ACK]) else $error("ack bit read nonzero");
	pend_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(re_i && addr_i == EIL_OFS_CTRL) |=> rdata_o[EIL_BIT_PEND] == $past(latch_q))
		else $error("pending flag wrong");
	break_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(break_i && !break_clear_enable_i && latch_q && !vec_fetch_i) |=> latch_q)
		else $error("latch cleared in break");
	reset_clr_a: assert property (@(posedge clk_i)
		!rst_n_i |=> (!latch_q && !mode_q)) else $error("reset left state");
	edge_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) fall_edge ##1 cpu_irq_o);
	lvl_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		mode_q && ack_pend_q ##[1:20] !latch_q);
	brk_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) break_i && sw_ack);
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the external interrupt latch.
// Assumes eil_pkg, eil_top and eil_pin_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import eil_pkg::*;
	logic              clk_i = 1'h0, rst_n_i = 1'h0, pull = 1'h0, vf = 1'h0, brk = 1'h0, bce = 1'h0;
	logic [EIL_AW-1:0] addr_i = 2'h0;
	logic [7:0]        wdata_i = 8'h00, rdata_o;
	logic              we_i = 1'h0, re_i = 1'h0, rv = 1'h0, pin_n, cpu_irq_o, pin_level_o, irq_o;
	logic [15:0]       vector_addr_o;
	logic [7:0]        exp_q[$];
	int                errors = 0, comparisons = 0, cyc = 0;
	logic [31:0]       seed = 32'h8d459945;
	always #20 clk_i = ~clk_i;
	eil_pin_model eil_pin_model_inst (.pull_low_i(pull), .pin_n_o(pin_n));
	eil_top eil_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .irq_pin_n_i(pin_n), .vec_fetch_i(vf),
		.break_i(brk), .break_clear_enable_i(bce), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
		.re_i(re_i), .rdata_o(rdata_o), .cpu_irq_o(cpu_irq_o), .vector_addr_o(vector_addr_o),
		.pin_level_o(pin_level_o), .irq_o(irq_o));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Read data stand only in the cycle after the strobe, so the oldest note is taken then.
	always @(posedge clk_i) begin
		cyc++;
		if (rv) chk("rdata_o", 16'(exp_q.pop_front()), 16'(rdata_o));
		rv = re_i;
		if (cyc == 4000) begin
			errors++;
			conclude();
		end
	end
	task automatic wr(input logic [EIL_AW-1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		we_i <= 1'h1;
		@(posedge clk_i);
		we_i <= 1'h0;
		@(negedge clk_i);
	endtask
	task automatic rd(input logic [EIL_AW-1:0] a, input logic [7:0] e);
		@(posedge clk_i);
		addr_i <= a;
		re_i <= 1'h1;
		exp_q.push_back(e);
		@(posedge clk_i);
		re_i <= 1'h0;
	endtask
	// Random hold time of 8 to 11 cycles varies the gap between pin changes; each change lands just after a rising edge.
	task automatic pin(input logic low);
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		@(posedge clk_i);
		pull <= low;
		repeat (8 + seed[1:0]) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'h1;
		rd(EIL_OFS_CTRL, 8'h00);
		chk("pin_level_o", 16'h1, 16'(pin_level_o));
		chk("vector_addr_o", 16'hfffa, vector_addr_o);
		$display("test reset done");
		wr(EIL_OFS_IRQ_EN, 8'h01);
		pin(1'h1);
		chk("cpu_irq_o", 16'h1, 16'(cpu_irq_o));
		chk("irq_o", 16'h1, 16'(irq_o));
		chk("pin_level_o", 16'h0, 16'(pin_level_o));
		rd(EIL_OFS_IRQ_ST, 8'h01);
		wr(EIL_OFS_CTRL, 8'h02);
		chk("cpu_irq_o", 16'h0, 16'(cpu_irq_o));
		rd(EIL_OFS_CTRL, 8'h0a);
		wr(EIL_OFS_IRQ_CLR, 8'h01);
		chk("irq_o", 16'h0, 16'(irq_o));
		wr(EIL_OFS_CTRL, 8'h04);
		rd(EIL_OFS_CTRL, 8'h00);
		$display("test edge done");
		pin(1'h0);
		pin(1'h1);
		rd(EIL_OFS_CTRL, 8'h08);
		@(posedge clk_i);
		vf <= 1'h1;
		@(posedge clk_i);
		vf <= 1'h0;
		rd(EIL_OFS_CTRL, 8'h00);
		pin(1'h0);
		$display("test fetch done");
		wr(EIL_OFS_CTRL, 8'h01);
		pin(1'h1);
		wr(EIL_OFS_CTRL, 8'h07);
		rd(EIL_OFS_CTRL, 8'h0b);
		pin(1'h0);
		rd(EIL_OFS_CTRL, 8'h03);
		$display("test level done");
		wr(EIL_OFS_CTRL, 8'h00);
		brk <= 1'h1;
		pin(1'h1);
		wr(EIL_OFS_CTRL, 8'h04);
		rd(EIL_OFS_CTRL, 8'h08);
		bce <= 1'h1;
		wr(EIL_OFS_CTRL, 8'h04);
		brk <= 1'h0;
		rd(EIL_OFS_CTRL, 8'h00);
		pin(1'h0);
		$display("test break done");
		wr(EIL_OFS_CTRL, 8'h01);
		pin(1'h1);
		@(posedge clk_i);
		rst_n_i <= 1'h0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'h1;
		rd(EIL_OFS_CTRL, 8'h00);
		chk("cpu_irq_o", 16'h0, 16'(cpu_irq_o));
		$display("test reset low done");
		conclude();
	end
endmodule
`default_nettype wire
